// ---- ocd_device.sv ----
// Contract
// - Frame is sixteen falling clocks, select low
// - Select low starts frame, falls shift data
// - Host avoids lowering select on falling edge
// - Last bit on 16th fall, execute on rise
// - Single device: rise between 16th, 17th fall
// - Rise before 15th fall aborts, nothing changes
// - Select low past 17th fall forwards data
// - Select stays high minimum time between frames
// - Idle data low, select high between frames
// - Chain of n needs n times sixteen falls
// - Clock at most 40 MHz, chained 30 MHz
// - Chain out low 14, high 15th, then data
// - All chained devices execute on shared rise
// - Eight channels, 8-bit straight binary code
// - Mode decides immediate or deferred output update
// - Register-only, write-through, plus mode-free commands
// - Opcode decoded from word bits 15 to 12
// - 1001 write-through, 1000 register-only, persistent
// - Bit 15 clear writes selected channel register
// - 1010 update mask, 1011 write A, 1100 broadcast
// - Reset clears registers and outputs to zero
module ocd_device (
    input wire logic clk,
    input wire logic nrst,
    ocd_link_if.dev link,
    output logic [ocd_pkg::CHANNELS*ocd_pkg::CODE_BITS-1:0] out_code,
    output logic [ocd_pkg::CHANNELS*ocd_pkg::CODE_BITS-1:0] reg_code,
    output logic write_through_mode,
    output logic frame_exec,
    output logic frame_abort,
    output logic [ocd_pkg::WORD_BITS-1:0] last_word
);
    localparam int CB = ocd_pkg::CODE_BITS;
    localparam int WB = ocd_pkg::WORD_BITS;

    logic [2:0] pins_s;
    logic sclk_s;
    logic sync_n_s;
    logic din_s;
    logic sclk_prev_reg;
    logic sync_n_prev_reg;
    logic fall;
    logic sync_rise;
    logic exec;
    logic [WB-1:0] shift_reg;
    logic [ocd_pkg::FALL_CNT_BITS-1:0] fall_cnt_reg;
    logic [ocd_pkg::FALL_CNT_BITS-1:0] fall_num;
    logic dout_reg;
    logic mode_reg;
    logic [3:0] opcode_field;
    logic [CB-1:0] data_field;

    // Link pins come from the host's clock; the link clock is sampled, not used as a clock
    // Idle-high pins pass inverted so a cleared synchroniser reads idle, no false edge
    ocd_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({~link.sclk, ~link.sync_n, link.din}),
        .q(pins_s)
    );

    assign sclk_s = ~pins_s[2];
    assign sync_n_s = ~pins_s[1];
    assign din_s = pins_s[0];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_reg <= 1'b1;
            sync_n_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_s;
            sync_n_prev_reg <= sync_n_s;
        end
    end

    // Falls only count while select is low
    assign fall = sclk_prev_reg && !sclk_s && !sync_n_s;
    assign sync_rise = !sync_n_prev_reg && sync_n_s;
    assign fall_num = fall_cnt_reg + 6'h01;

    // Shorter frames are dropped whole
    assign exec = sync_rise && (fall_cnt_reg >= ocd_pkg::FALL_ABORT_LIMIT);

    // Input register, most significant bit arrives first
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= '0;
        end else if (fall) begin
            shift_reg <= {shift_reg[WB-2:0], din_s};
        end
    end

    // Counter saturates so long chain frames cannot wrap back into the marker
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fall_cnt_reg <= '0;
        end else if (sync_n_s) begin
            fall_cnt_reg <= '0;
        end else if (fall && fall_cnt_reg != ocd_pkg::FALL_CNT_MAX) begin
            fall_cnt_reg <= fall_num;
        end
    end

    // Chain output: zeros, marker, then the word delayed by one frame
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dout_reg <= 1'b0;
        end else if (sync_n_s) begin
            dout_reg <= 1'b0;
        end else if (fall) begin
            // Old count compared: the next count wraps once the counter saturates
            if (fall_cnt_reg < ocd_pkg::FALL_MARKER - 6'h01) begin
                dout_reg <= 1'b0;
            end else if (fall_cnt_reg == ocd_pkg::FALL_MARKER - 6'h01) begin
                dout_reg <= 1'b1;
            end else begin
                // Bit taken fifteen falls ago plus this flop makes sixteen stages
                dout_reg <= shift_reg[ocd_pkg::ECHO_TAP];
            end
        end
    end

    assign link.dout = dout_reg;

    assign opcode_field = shift_reg[ocd_pkg::OPCODE_MSB:ocd_pkg::OPCODE_LSB];
    assign data_field = shift_reg[ocd_pkg::DATA_MSB:ocd_pkg::DATA_LSB];

    function automatic logic reg_hit(
        input logic [WB-1:0] w,
        input logic [2:0] ch
    );
        logic [3:0] op;
        logic direct;
        op = w[ocd_pkg::OPCODE_MSB:ocd_pkg::OPCODE_LSB];
        direct = !w[ocd_pkg::DIRECT_WRITE_BIT];
        reg_hit = (direct && w[ocd_pkg::CHSEL_MSB:ocd_pkg::CHSEL_LSB] == ch)
            || (op == ocd_pkg::OP_WRITE_A_ALL && ch == 3'h0)
            || (op == ocd_pkg::OP_BROADCAST);
    endfunction

    function automatic logic out_hit(
        input logic [WB-1:0] w,
        input logic [2:0] ch,
        input logic wt
    );
        logic [3:0] op;
        logic direct;
        logic [ocd_pkg::MASK_MSB:ocd_pkg::MASK_LSB] mask;
        op = w[ocd_pkg::OPCODE_MSB:ocd_pkg::OPCODE_LSB];
        direct = !w[ocd_pkg::DIRECT_WRITE_BIT];
        mask = w[ocd_pkg::MASK_MSB:ocd_pkg::MASK_LSB];
        out_hit = (direct && wt && w[ocd_pkg::CHSEL_MSB:ocd_pkg::CHSEL_LSB] == ch)
            || (op == ocd_pkg::OP_UPDATE_SEL && mask[ch])
            || (op == ocd_pkg::OP_WRITE_A_ALL)
            || (op == ocd_pkg::OP_BROADCAST);
    endfunction

    // Mode persists across frames; other opcodes leave it alone
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= ocd_pkg::MODE_RESET;
        end else if (exec && opcode_field == ocd_pkg::OP_WRITE_THRU) begin
            mode_reg <= 1'b1;
        end else if (exec && opcode_field == ocd_pkg::OP_REG_ONLY) begin
            mode_reg <= 1'b0;
        end
    end

    assign write_through_mode = mode_reg;

    // Each channel: data register and the code driving its converter
    genvar g;
    generate
        for (g = 0; g < ocd_pkg::CHANNELS; g++) begin : g_chan
            logic [CB-1:0] data_reg;
            logic [CB-1:0] level_reg;
            logic wr;

            assign wr = reg_hit(shift_reg, 3'(g));

            // Everything acts on the one shared select rise
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    data_reg <= ocd_pkg::CODE_RESET;
                end else if (exec && wr) begin
                    data_reg <= data_field;
                end
            end

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    level_reg <= ocd_pkg::CODE_RESET;
                end else if (exec && out_hit(shift_reg, 3'(g), mode_reg)) begin
                    // New data bypasses the register so both change together
                    level_reg <= wr ? data_field : data_reg;
                end
            end

            assign reg_code[g*CB +: CB] = data_reg;
            assign out_code[g*CB +: CB] = level_reg;
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_exec <= 1'b0;
            frame_abort <= 1'b0;
        end else begin
            frame_exec <= exec;
            frame_abort <= sync_rise && !exec;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_word <= '0;
        end else if (exec) begin
            last_word <= shift_reg;
        end
    end
endmodule

// ---- ocd_host.sv ----
module ocd_host #(
    parameter int CHAIN_LEN = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [16*CHAIN_LEN-1:0] words,
    output logic busy,
    output logic done,
    ocd_link_if.host link
);
    localparam int TOTAL = ocd_pkg::WORD_BITS * CHAIN_LEN;
    localparam int MAXW = (ocd_pkg::SYNC_GAP_CYC > ocd_pkg::SCLK_HALF_CYC) ?
        ocd_pkg::SYNC_GAP_CYC : ocd_pkg::SCLK_HALF_CYC;
    localparam int TW = $clog2(MAXW + 1);
    localparam int BW = $clog2(TOTAL + 1);
    localparam int SCLK_NS = 2 * ocd_pkg::SCLK_HALF_CYC * ocd_pkg::CLK_PERIOD_NS;
    localparam int MAX_MHZ = (CHAIN_LEN > 1) ?
        ocd_pkg::SCLK_MAX_CHAIN_MHZ : ocd_pkg::SCLK_MAX_SINGLE_MHZ;

    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} ocd_hstate_t;

    ocd_hstate_t state_reg;
    logic [TW-1:0] timer_reg;
    logic [BW-1:0] bit_cnt_reg;
    logic [TOTAL-1:0] words_reg;
    logic sclk_reg;
    logic sync_n_reg;
    logic din_reg;
    logic tick;
    logic last_fall;

    initial begin
        if (CHAIN_LEN < 1) $error("ocd_host: CHAIN_LEN must be at least 1");
        if (SCLK_NS * MAX_MHZ < 1000) $error("ocd_host: serial clock too fast");
    end

    assign tick = (timer_reg == '0);
    assign last_fall = (bit_cnt_reg == BW'(TOTAL - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= H_IDLE;
            timer_reg <= '0;
        end else begin
            unique case (state_reg)
                H_IDLE: begin
                    if (start) begin
                        state_reg <= H_SETUP;
                        timer_reg <= TW'(ocd_pkg::SCLK_HALF_CYC - 1);
                    end
                end
                H_SETUP, H_HIGH: begin
                    if (tick) begin
                        state_reg <= H_LOW;
                        timer_reg <= TW'(ocd_pkg::SCLK_HALF_CYC - 1);
                    end else begin
                        timer_reg <= timer_reg - 1'b1;
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        state_reg <= last_fall ? H_HOLD : H_HIGH;
                        timer_reg <= TW'(ocd_pkg::SCLK_HALF_CYC - 1);
                    end else begin
                        timer_reg <= timer_reg - 1'b1;
                    end
                end
                H_HOLD: begin
                    if (tick) begin
                        state_reg <= H_GAP;
                        timer_reg <= TW'(ocd_pkg::SYNC_GAP_CYC - 1);
                    end else begin
                        timer_reg <= timer_reg - 1'b1;
                    end
                end
                H_GAP: begin
                    if (tick) begin
                        state_reg <= H_IDLE;
                    end else begin
                        timer_reg <= timer_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    // Clock idles high so select never falls on a falling clock edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_reg <= 1'b1;
            sync_n_reg <= 1'b1;
            din_reg <= 1'b0;
            words_reg <= '0;
            bit_cnt_reg <= '0;
        end else begin
            if (state_reg == H_IDLE && start) begin
                sync_n_reg <= 1'b0;
                words_reg <= words;
                din_reg <= words[TOTAL-1];
                bit_cnt_reg <= '0;
            end
            if ((state_reg == H_SETUP || state_reg == H_HIGH) && tick) begin
                sclk_reg <= 1'b0;
            end
            if (state_reg == H_LOW && tick) begin
                sclk_reg <= 1'b1;
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
                if (!last_fall) begin
                    // Data changes on the rising edge, stable at the next fall
                    words_reg <= {words_reg[TOTAL-2:0], 1'b0};
                    din_reg <= words_reg[TOTAL-2];
                end
            end
            if (state_reg == H_HOLD && tick) begin
                sync_n_reg <= 1'b1;
                din_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= (state_reg == H_GAP) && tick;
            if (state_reg == H_IDLE && start) begin
                busy <= 1'b1;
            end else if (state_reg == H_GAP && tick) begin
                busy <= 1'b0;
            end
        end
    end

    assign link.sclk = sclk_reg;
    assign link.sync_n = sync_n_reg;
    assign link.din = din_reg;
endmodule

// ---- ocd_link_assertions.sv ----
module ocd_link_assertions #(
    parameter int CHAIN_LEN = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FALLS = 16 * CHAIN_LEN;
    logic sclk_reg;
    logic [5:0] fall_cnt_reg;
    logic [14:0] hist_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_reg <= 1'b1;
        end else begin
            sclk_reg <= sclk;
        end
    end

    // Saturates so an overlong frame cannot wrap into a legal count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fall_cnt_reg <= 6'h00;
        end else if (sync_n) begin
            fall_cnt_reg <= 6'h00;
        end else if (sclk_reg && !sclk && fall_cnt_reg != 6'h3F) begin
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hist_reg <= 15'h0000;
        end else if (sclk_reg && !sclk && !sync_n) begin
            hist_reg <= {hist_reg[13:0], din};
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property fwd_p;
        logic b;
        (sclk_reg && !sclk && !sync_n && fall_cnt_reg > 6'h0E, b = hist_reg[14])
            |-> ##3 dout == b;
    endproperty

    sel_setup_a: assert property ($fell(sync_n) |-> sclk [*4] ##1 !sclk)
        else $error("select fell too close to a clock fall");
    fall_count_a: assert property ($rose(sync_n) |-> fall_cnt_reg == FALLS)
        else $error("frame closed with wrong number of clock falls");
    idle_lines_a: assert property (sync_n |-> sclk && !din)
        else $error("clock or data not idle between frames");
    data_hold_a: assert property (!sclk |-> $stable(din))
        else $error("data moved while clock low");
    low_phase_a: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
        else $error("clock low phase not four cycles");
    high_phase_a: assert property ($rose(sclk) && !sync_n |-> sclk [*4])
        else $error("clock high phase too short");
    out_low_a: assert property ($fell(sclk) && !sync_n && fall_cnt_reg < 6'h0E |-> ##3 !dout)
        else $error("chain output high during first falls");
    out_mark_a: assert property ($fell(sclk) && !sync_n && fall_cnt_reg == 6'h0E |-> ##3 dout)
        else $error("chain output marker missing");
    out_fwd_a: assert property (fwd_p)
        else $error("chain output bit wrong");
    idle_out_a: assert property (sync_n [*5] |-> !dout)
        else $error("chain output active outside frame");

    frame_c: cover property ($rose(sync_n) && fall_cnt_reg == 6'h10);
    mark_c: cover property ($fell(sclk) && fall_cnt_reg == 6'h0E);
    fwd_c: cover property ($rose(dout));
endmodule

// ---- ocd_link_if.sv ----
interface ocd_link_if;
    logic sclk;
    logic sync_n;
    logic din;
    logic dout;

    modport dev (
        input sclk,
        input sync_n,
        input din,
        output dout
    );

    modport host (
        output sclk,
        output sync_n,
        output din
    );
endinterface

// ---- ocd_pkg.sv ----
package ocd_pkg;
    localparam int WORD_BITS = 16;
    localparam int CHANNELS = 8;
    localparam int CODE_BITS = 8;
    localparam int OPCODE_MSB = 15;
    localparam int OPCODE_LSB = 12;
    localparam int CHSEL_MSB = 14;
    localparam int CHSEL_LSB = 12;
    localparam int DATA_MSB = 11;
    localparam int DATA_LSB = 4;
    localparam int MASK_MSB = 7;
    localparam int MASK_LSB = 0;
    localparam int DIRECT_WRITE_BIT = 15;
    localparam logic [3:0] OP_REG_ONLY = 4'h8;
    localparam logic [3:0] OP_WRITE_THRU = 4'h9;
    localparam logic [3:0] OP_UPDATE_SEL = 4'hA;
    localparam logic [3:0] OP_WRITE_A_ALL = 4'hB;
    localparam logic [3:0] OP_BROADCAST = 4'hC;
    localparam int FALL_CNT_BITS = 6;
    localparam logic [5:0] FALL_ABORT_LIMIT = 6'h0F;
    localparam logic [5:0] FALL_MARKER = 6'h0F;
    localparam logic [5:0] FALL_CNT_MAX = 6'h3F;
    localparam int ECHO_TAP = 14;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic MODE_RESET = 1'b0;
    localparam int SYNC_STAGES = 2;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS = 800;
    localparam int SCLK_HALF_CYC_RAW = SCLK_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_CYC_RAW < 1) ? 1 : SCLK_HALF_CYC_RAW;
    localparam int SYNC_HIGH_MIN_NS = 15;
    localparam int SYNC_HIGH_CYC = (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_GAP_CYC = SYNC_HIGH_CYC + 2 * SCLK_HALF_CYC;
    localparam int SCLK_MAX_SINGLE_MHZ = 40;
    localparam int SCLK_MAX_CHAIN_MHZ = 30;
endpackage

// ---- ocd_sync.sv ----
module ocd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    initial begin
        if (WIDTH < 1) $error("ocd_sync: WIDTH must be at least 1");
    end

    // Meta stage feeds only the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ---- octal_dac_serial_write_control_tb.sv ----
module octal_dac_serial_write_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic [15:0] words = 16'h0000;
    logic busy, done, mode, ab_b;
    logic ex_a, ab_a, ex_b;
    logic [15:0] word_b;
    logic abort_seen = 1'b0;
    int exec_a = 0;
    int abort_a = 0;
    int exec_b = 0;
    logic [63:0] out_code, reg_code, out_b, reg_b, exp_reg, exp_out;
    logic [15:0] last_word;
    logic exp_mode;
    logic [31:0] seen;
    logic [15:0] cmds [16];
    int fail_count = 0;
    int compares = 0;

    ocd_link_if link_a ();
    ocd_link_if link_b ();

    always #50 clk = ~clk;

    ocd_host #(.CHAIN_LEN(1)) i_ocd_host (.clk(clk), .nrst(nrst), .start(start),
        .words(words), .busy(busy), .done(done), .link(link_a.host));
    ocd_device i_ocd_device (.clk(clk), .nrst(nrst), .link(link_a.dev), .out_code(out_code),
        .reg_code(reg_code), .write_through_mode(mode), .frame_exec(ex_a), .frame_abort(ab_a),
        .last_word(last_word));
    // Second device fed by the bench so frames can be cut short or stretched
    ocd_device i_ocd_device_b (.clk(clk), .nrst(nrst), .link(link_b.dev), .out_code(out_b),
        .reg_code(reg_b), .write_through_mode(), .frame_exec(ex_b), .frame_abort(ab_b),
        .last_word(word_b));
    ocd_link_assertions #(.CHAIN_LEN(1)) i_ocd_link_assertions (.clk(clk), .nrst(nrst),
        .sclk(link_a.sclk), .sync_n(link_a.sync_n), .din(link_a.din), .dout(link_a.dout));

    always @(posedge clk) begin
        if (ab_b === 1'b1) abort_seen <= 1'b1;
        if (ex_a === 1'b1) exec_a <= exec_a + 1;
        if (ab_a === 1'b1) abort_a <= abort_a + 1;
        if (ex_b === 1'b1) exec_b <= exec_b + 1;
    end

    task check(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task send(input logic [15:0] w);
        int n;
        @(negedge clk);
        words = w;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        check({63'h0, busy}, 64'h1, "busy high");
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n == 400) begin
            fail_count++;
            $display("unexpected at %0t: host never finished", $time);
        end
        check({63'h0, busy}, 64'h0, "busy low");
    endtask

    task model(input logic [15:0] w);
        logic [7:0] d;
        int k;
        d = w[11:4];
        if (w[15] == 1'b0) begin
            exp_reg[w[14:12]*8 +: 8] = d;
            if (exp_mode) exp_out[w[14:12]*8 +: 8] = d;
        end else begin
            case (w[15:12])
                4'h8: exp_mode = 1'b0;
                4'h9: exp_mode = 1'b1;
                4'hA: for (k = 0; k < 8; k++) if (w[k]) exp_out[k*8 +: 8] = exp_reg[k*8 +: 8];
                4'hB: begin
                    exp_reg[7:0] = d;
                    exp_out = exp_reg;
                end
                4'hC: begin
                    exp_reg = {8{d}};
                    exp_out = exp_reg;
                end
                default: ;
            endcase
        end
    endtask

    // Bench plays host on the second link; n falls, bits sent from the top
    task frame_b(input logic [31:0] bits, input int n);
        int i;
        seen = 32'h0000_0000;
        @(negedge clk);
        link_b.sync_n = 1'b0;
        for (i = 0; i < n; i++) begin
            link_b.din = bits[31-i];
            repeat (4) @(negedge clk);
            link_b.sclk = 1'b0;
            repeat (4) @(negedge clk);
            seen[31-i] = link_b.dout;
            link_b.sclk = 1'b1;
        end
        repeat (4) @(negedge clk);
        link_b.sync_n = 1'b1;
        link_b.din = 1'b0;
        repeat (10) @(negedge clk);
    endtask

    initial begin
        link_b.sclk = 1'b1;
        link_b.sync_n = 1'b1;
        link_b.din = 1'b0;
        exp_reg = 64'h0;
        exp_out = 64'h0;
        exp_mode = 1'b0;
        cmds = '{16'h01F0, 16'h13F0, 16'h25F0, 16'h37F0, 16'h49F0, 16'h5BF0, 16'h6DF0,
            16'h7FF0, 16'hA005, 16'h9000, 16'h35A0, 16'h8000, 16'h1330, 16'hBC30,
            16'hD0FF, 16'hC800};
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check(reg_code, 64'h0, "reset regs");
        check(out_code, 64'h0, "reset outs");
        check({63'h0, mode}, 64'h0, "reset mode");
        foreach (cmds[j]) begin
            send(cmds[j]);
            model(cmds[j]);
            check(reg_code, exp_reg, "regs");
            check(out_code, exp_out, "outs");
            check({63'h0, mode}, {63'h0, exp_mode}, "mode");
            if (cmds[j][15:12] != 4'hD)
                check({48'h0, last_word}, {48'h0, cmds[j]}, "word");
        end
        check({32'h0, exec_a}, 64'h10, "exec count");
        check({32'h0, abort_a}, 64'h0, "abort count");
        // Fourteen falls only: the broadcast must be thrown away
        frame_b({16'hC7F0, 16'h0000}, 14);
        check(reg_b, 64'h0, "abort regs");
        check(out_b, 64'h0, "abort outs");
        check({63'h0, abort_seen}, 64'h1, "abort flag");
        check({32'h0, seen}, 64'h0, "abort chain");
        check({32'h0, exec_b}, 64'h0, "abort exec");
        // Two words in one frame: first leaves on the chain, second executes
        frame_b({16'hA5C3, 16'hC7E0}, 32);
        check({32'h0, seen}, {32'h0, 14'h0000, 1'b1, 16'hA5C3, 1'b1}, "chain");
        check(reg_b, {8{8'h7E}}, "chain regs");
        check(out_b, {8{8'h7E}}, "chain outs");
        check({32'h0, exec_b}, 64'h1, "chain exec");
        check({48'h0, word_b}, 64'hC7E0, "chain word");
        results();
    end

    initial begin
        repeat (8000) @(posedge clk);
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end
endmodule
